// ===== shared/ais_pkg.sv
// Purpose: shared types and constants for the alu instruction subset
// Assumes: 8-bit data, 7-bit file addresses
// Notes:   operations arrive as one-cycle requests from the decoder
`default_nettype none
//==========================================================
// package
package ais_pkg;

    localparam logic [7:0] AIS_RST_BYTE  = 8'h00;  // value after reset
    localparam logic [7:0] AIS_WDT_CLEAR = 8'h00;  // watchdog count on sleep
    localparam logic [7:0] AIS_PSC_CLEAR = 8'h00;  // prescaler on sleep
    localparam logic [7:0] AIS_DIR_RST   = 8'hff;  // direction after reset
    localparam logic [2:0] AIS_DIR_SEL_A = 3'h5;   // port a direction select
    localparam logic [2:0] AIS_DIR_SEL_B = 3'h6;   // port b direction select
    localparam logic [2:0] AIS_DIR_SEL_C = 3'h7;   // port c direction select
    localparam int         AIS_NIB_HI    = 7;      // high nibble top bit
    localparam int         AIS_NIB_LO    = 3;      // low nibble top bit

    // operation codes, one-hot apart from AIS_OP_NONE
    typedef enum logic [9:0] {
        AIS_OP_NONE   = 10'h000,
        AIS_OP_RRC    = 10'h001,  // rotate_right_carry
        AIS_OP_LSUB   = 10'h002,  // literal_minus_acc
        AIS_OP_FSUB   = 10'h004,  // file_minus_acc
        AIS_OP_FSUBB  = 10'h008,  // sub_file_borrow
        AIS_OP_NIBX   = 10'h010,  // nibble_exchange
        AIS_OP_DIRLD  = 10'h020,  // direction_register_load
        AIS_OP_XORL   = 10'h040,  // xor_literal_acc
        AIS_OP_XORF   = 10'h080,  // xor_file_acc
        AIS_OP_SLEEP  = 10'h100   // sleep entry
    } ais_op_type;

    // one instruction request from the decoder
    typedef struct packed {
        logic        valid;    // request present this cycle
        ais_op_type  op;       // operation
        logic [6:0]  faddr;    // file address 0..127
        logic        dest;     // 0 accumulator, 1 file
        logic [7:0]  operand;  // literal, or direction select in low bits
    } ais_req_type;

    // file register write request toward the register file
    typedef struct packed {
        logic        we;       // write strobe
        logic [6:0]  addr;     // file address
        logic [7:0]  data;     // written value
    } ais_fwr_type;

    // status flags
    typedef struct packed {
        logic carry;           // carry / not borrow
        logic nib;             // nibble_borrow_flag
        logic zero;            // zero flag
        logic sleep_entered;   // sleep_entered_flag, active low sense
        logic expiry;          // expiry_flag, active low sense
    } ais_flags_type;

    localparam ais_flags_type AIS_FLAGS_RST = '{carry: 1'b0, nib: 1'b0,
        zero: 1'b0, sleep_entered: 1'b1, expiry: 1'b1};

endpackage : ais_pkg
`default_nettype wire

// ===== rtl/ais_alu.sv
// Purpose: execution datapath for a subset of an 8-bit instruction set
// Assumes: file operand value is read by the decoder and presented
//          alongside the request in the same cycle
// Notes:   results and flags update one clock after a valid request
`timescale 1ns/10ps
`default_nettype none

module ais_alu (
    input  wire logic                  core_clk_i,   // core clock
    input  wire logic                  rst_i,        // sync reset, high
    input  wire ais_pkg::ais_req_type  req_i,        // instruction request
    input  wire logic [7:0]            file_rd_i,    // addressed file value
    input  wire logic                  wdt_tick_i,   // prescaler input tick
    output logic [7:0]                 acc_o,        // accumulator
    output ais_pkg::ais_flags_type     flags_o,      // status flags
    output ais_pkg::ais_fwr_type       file_wr_o,    // file write request
    output logic [7:0]                 dir_a_o,      // port_a_direction
    output logic [7:0]                 dir_b_o,      // port_b_direction
    output logic [7:0]                 dir_c_o,      // port_c_direction
    output logic [7:0]                 wdt_count_o,  // watchdog_counter
    output logic                       sleep_o       // sleep state
);

    //==========================================================
    // helper functions
    // low nibble top bit, held locally so the function can use it
    localparam int AIS_NIB_LO_L = ais_pkg::AIS_NIB_LO;

    // a - b - borrow_in, returns {carry, nibble carry, result}
    // formed as a + ~b + ~borrow: carry out then means no borrow,
    // which is the sense the status flags keep
    function automatic logic [9:0] sub_flags(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       bin);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + {8'h00, ~bin};
        low  = {1'b0, a[AIS_NIB_LO_L:0]} + {1'b0, ~b[AIS_NIB_LO_L:0]}
             + {4'h0, ~bin};
        return {full[8], low[4], full[7:0]};
    endfunction : sub_flags

    //==========================================================
    // state
    logic [7:0]              acc_r,   acc_nxt;
    ais_pkg::ais_flags_type  flg_r,   flg_nxt;
    ais_pkg::ais_fwr_type    fwr_r,   fwr_nxt;
    logic [7:0]              dira_r,  dira_nxt;
    logic [7:0]              dirb_r,  dirb_nxt;
    logic [7:0]              dirc_r,  dirc_nxt;
    logic [7:0]              wdt_r,   wdt_nxt;
    // the prescaler stays inside; only the count leaves the block
    logic [7:0]              psc_r,   psc_nxt;
    logic                    slp_r,   slp_nxt;

    //==========================================================
    // next-state computation
    // one result path shared by every file op keeps the dest mux single
    always_comb begin
        logic [7:0] res;
        logic [9:0] sr;
        logic       wr_res;
        logic       upd_z;
        res      = 8'h00;
        sr       = 10'h000;
        wr_res   = 1'b0;
        upd_z    = 1'b0;
        acc_nxt  = acc_r;
        flg_nxt  = flg_r;
        fwr_nxt  = '{we: 1'b0, addr: req_i.faddr, data: 8'h00};
        dira_nxt = dira_r;
        dirb_nxt = dirb_r;
        dirc_nxt = dirc_r;
        psc_nxt  = psc_r;
        wdt_nxt  = wdt_r;
        slp_nxt  = slp_r;
        // watchdog prescaler and counter run free between sleeps
        // sleep below overrides a tick in the same cycle
        if (wdt_tick_i) begin
            psc_nxt = psc_r + 8'h01;
            if (psc_r == 8'hff) begin
                wdt_nxt = wdt_r + 8'h01;
            end
        end
        if (req_i.valid) begin
            slp_nxt = 1'b0;  // any executed request but sleep means awake
            case (req_i.op)
                ais_pkg::AIS_OP_RRC: begin
                    res = {flg_r.carry, file_rd_i[7:1]};
                    flg_nxt.carry = file_rd_i[0];
                    wr_res = 1'b1;
                end
                ais_pkg::AIS_OP_LSUB: begin
                    sr = sub_flags(req_i.operand, acc_r, 1'b0);
                    res = sr[7:0];
                    flg_nxt.carry = sr[9];
                    flg_nxt.nib   = sr[8];
                    upd_z   = 1'b1;
                    acc_nxt = res;  // always to the accumulator
                end
                ais_pkg::AIS_OP_FSUB: begin
                    sr = sub_flags(file_rd_i, acc_r, 1'b0);
                    res = sr[7:0];
                    flg_nxt.carry = sr[9];
                    flg_nxt.nib   = sr[8];
                    upd_z  = 1'b1;
                    wr_res = 1'b1;
                end
                ais_pkg::AIS_OP_FSUBB: begin
                    // borrow is the inverted carry
                    sr = sub_flags(file_rd_i, acc_r,
                                   ~flg_r.carry);
                    res = sr[7:0];
                    flg_nxt.carry = sr[9];
                    flg_nxt.nib   = sr[8];
                    upd_z  = 1'b1;
                    wr_res = 1'b1;
                end
                ais_pkg::AIS_OP_NIBX: begin
                    res = {file_rd_i[3:0], file_rd_i[7:4]};
                    wr_res = 1'b1;
                end
                ais_pkg::AIS_OP_DIRLD: begin
                    // other select values are ignored
                    case (req_i.operand[2:0])
                        ais_pkg::AIS_DIR_SEL_A: dira_nxt = acc_r;
                        ais_pkg::AIS_DIR_SEL_B: dirb_nxt = acc_r;
                        ais_pkg::AIS_DIR_SEL_C: dirc_nxt = acc_r;
                        default: ;
                    endcase
                end
                ais_pkg::AIS_OP_XORL: begin
                    res = acc_r ^ req_i.operand;
                    upd_z   = 1'b1;
                    acc_nxt = res;
                end
                ais_pkg::AIS_OP_XORF: begin
                    res = acc_r ^ file_rd_i;
                    upd_z  = 1'b1;
                    wr_res = 1'b1;
                end
                ais_pkg::AIS_OP_SLEEP: begin
                    flg_nxt.sleep_entered = 1'b0;
                    flg_nxt.expiry        = 1'b1;
                    // sleep_o falls at the next taken request
                    slp_nxt = 1'b1;
                    wdt_nxt = ais_pkg::AIS_WDT_CLEAR;
                    psc_nxt = ais_pkg::AIS_PSC_CLEAR;
                end
                default: ;
            endcase
            // zero judged on the 8-bit result alone
            if (upd_z) begin
                flg_nxt.zero = (res == 8'h00);
            end
            // literal ops never raise wr_res, so their dest bit is moot
            if (wr_res) begin
                if (req_i.dest) begin
                    fwr_nxt.we   = 1'b1;
                    fwr_nxt.data = res;
                end else begin
                    acc_nxt = res;
                end
            end
        end
    end

    //==========================================================
    // registers
    // sync reset: a request seen during reset is dropped, not queued
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_r  <= ais_pkg::AIS_RST_BYTE;
            flg_r  <= ais_pkg::AIS_FLAGS_RST;
            fwr_r  <= '{we: 1'b0, addr: 7'h00, data: 8'h00};
            dira_r <= ais_pkg::AIS_DIR_RST;  // pins start as inputs
            dirb_r <= ais_pkg::AIS_DIR_RST;
            dirc_r <= ais_pkg::AIS_DIR_RST;
            wdt_r  <= ais_pkg::AIS_RST_BYTE;
            psc_r  <= ais_pkg::AIS_RST_BYTE;
            slp_r  <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            flg_r  <= flg_nxt;
            fwr_r  <= fwr_nxt;
            dira_r <= dira_nxt;
            dirb_r <= dirb_nxt;
            dirc_r <= dirc_nxt;
            wdt_r  <= wdt_nxt;
            psc_r  <= psc_nxt;
            slp_r  <= slp_nxt;
        end
    end

    //==========================================================
    // outputs straight from flops
    // no gates after the flops, so output timing is clock to q
    assign acc_o       = acc_r;
    assign flags_o     = flg_r;
    assign file_wr_o   = fwr_r;
    assign dir_a_o     = dira_r;
    assign dir_b_o     = dirb_r;
    assign dir_c_o     = dirc_r;
    assign wdt_count_o = wdt_r;
    assign sleep_o     = slp_r;

endmodule : ais_alu
`default_nettype wire

// ===== tb/ais_alu_chk.sv
// Purpose: port checks for ais_alu
// Assumes: results show one clock after a taken request
// Notes:   bound to ais_alu at the foot of this file
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// checker
module ais_alu_chk (
    input wire logic                   core_clk_i,  // clock
    input wire logic                   rst_i,       // reset
    input wire ais_pkg::ais_req_type   req_i,       // request
    input wire logic [7:0]             file_rd_i,   // file value
    input wire logic [7:0]             acc_o,       // accumulator
    input wire ais_pkg::ais_flags_type flags_o,     // flags
    input wire ais_pkg::ais_fwr_type   file_wr_o,   // file write
    input wire logic [7:0]             dir_a_o,     // direction a
    input wire logic [7:0]             dir_b_o,     // direction b
    input wire logic [7:0]             wdt_count_o, // watchdog
    input wire logic                   sleep_o      // sleep state
);
    logic [9:0] op_w;  // op of a valid request, else none
    // invalid requests must never arm a check
    assign op_w = req_i.valid ? req_i.op : 10'h000;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    //==========================================================
    // each request shows its effect one edge later
    chk_xorl_zero :
    assert property (op_w == ais_pkg::AIS_OP_XORL |=> acc_o == ($past(acc_o)
        ^ $past(req_i.operand)) && flags_o.zero == (acc_o == 8'h00))
        else $error("xor literal result wrong");
    chk_xorf_dest :
    assert property (op_w == ais_pkg::AIS_OP_XORF && req_i.dest |=>
        file_wr_o.we && file_wr_o.data == ($past(acc_o) ^ $past(file_rd_i))
        && $stable(acc_o)) else $error("xor file write wrong");
    chk_lsub_carry :
    assert property (op_w == ais_pkg::AIS_OP_LSUB |=> flags_o.carry ==
        ($past(acc_o) <= $past(req_i.operand)) && acc_o ==
        $past(req_i.operand) - $past(acc_o)) else $error("lit sub wrong");
    chk_fsubb_borrow :
    assert property (op_w == ais_pkg::AIS_OP_FSUBB |=> flags_o.carry ==
        ({1'b0, $past(file_rd_i)} >= {1'b0, $past(acc_o)} +
        {8'h00, !$past(flags_o.carry)})) else $error("borrow sub wrong");
    chk_rrc_carry :
    assert property (op_w == ais_pkg::AIS_OP_RRC && !req_i.dest |=>
        acc_o[7] == $past(flags_o.carry) && acc_o[6:0] == $past(file_rd_i[7:1])
        && flags_o.carry == $past(file_rd_i[0])) else $error("rotate wrong");
    chk_nibx_flags :
    assert property (op_w == ais_pkg::AIS_OP_NIBX |=> $stable(flags_o))
        else $error("swap changed flags");
    chk_dir_load :
    assert property (op_w == ais_pkg::AIS_OP_DIRLD && req_i.operand[2:0] ==
        ais_pkg::AIS_DIR_SEL_B |=> dir_b_o == $past(acc_o) && $stable(dir_a_o))
        else $error("direction load wrong");
    chk_sleep_entry :
    assert property (op_w == ais_pkg::AIS_OP_SLEEP |=> sleep_o &&
        !flags_o.sleep_entered && flags_o.expiry && wdt_count_o == 8'h00)
        else $error("sleep entry wrong");
    chk_fsub_dest :
    assert property (op_w == ais_pkg::AIS_OP_FSUB && req_i.dest |=>
        file_wr_o.we && file_wr_o.data == $past(file_rd_i) - $past(acc_o)
        && $stable(acc_o)) else $error("file subtract write wrong");
    chk_nibx_result :
    assert property (op_w == ais_pkg::AIS_OP_NIBX && !req_i.dest |=>
        acc_o == {$past(file_rd_i[3:0]), $past(file_rd_i[7:4])})
        else $error("nibble swap result wrong");
endmodule : ais_alu_chk

bind ais_alu ais_alu_chk u_chk (.core_clk_i, .rst_i, .req_i, .file_rd_i,
    .acc_o, .flags_o, .file_wr_o, .dir_a_o, .dir_b_o, .wdt_count_o, .sleep_o);
`default_nettype wire

// ===== tb/test_alu_instruction_subset.sv
// Purpose: directed bench for ais_alu
// Assumes: inputs change on the falling edge
// Notes:   run() keeps a small model that forms its expectations; watchdog counts are checked against constants
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// bench
module test_alu_instruction_subset;
    logic                   core_clk_i = 1'b0;  // clock
    logic                   rst_i = 1'b1;       // reset
    ais_pkg::ais_req_type   req_i = '0;         // request
    logic [7:0]             file_rd_i = 8'h00;  // file value
    logic                   wdt_tick_i = 1'b0;  // prescaler tick
    logic [7:0]             acc_o, dir_a_o, dir_b_o, dir_c_o, wdt_count_o;
    ais_pkg::ais_flags_type flags_o, m_f;       // flags, model flags
    ais_pkg::ais_fwr_type   file_wr_o;          // file write
    logic                   sleep_o;            // sleep state
    logic [7:0]             m_acc = 8'h00;      // model accumulator
    logic [7:0]             m_dir [3];          // model directions
    int                     failures = 0;
    int                     n_tests = 0;
    always #20 core_clk_i = ~core_clk_i;
    ais_alu uut (.core_clk_i, .rst_i, .req_i, .file_rd_i, .wdt_tick_i, .acc_o,
        .flags_o, .file_wr_o, .dir_a_o, .dir_b_o, .dir_c_o, .wdt_count_o,
        .sleep_o);
    //==========================================================
    // compare and report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // one request taken at the next edge; valid is left up for chaining
    task automatic run(input ais_pkg::ais_op_type op, input logic d,
                       input logic [7:0] k, input logic [7:0] f);
        logic [8:0] r;
        logic [4:0] n;
        logic       b;
        logic       wr;
        r = {1'b0, m_acc};
        wr = 1'b0;
        case (op)
            ais_pkg::AIS_OP_RRC: begin
                r = {1'b0, m_f.carry, f[7:1]};
                m_f.carry = f[0];
                wr = d;
            end
            ais_pkg::AIS_OP_LSUB, ais_pkg::AIS_OP_FSUB,
            ais_pkg::AIS_OP_FSUBB: begin
                b = (op == ais_pkg::AIS_OP_FSUBB) ? !m_f.carry : 1'b0;
                r = {1'b0, (op == ais_pkg::AIS_OP_LSUB) ? k : f} - m_acc - b;
                n = {1'b0, (op == ais_pkg::AIS_OP_LSUB) ? k[3:0] : f[3:0]}
                    - m_acc[3:0] - b;
                m_f.carry = !r[8];
                m_f.nib = !n[4];
                m_f.zero = (r[7:0] == 8'h00);
                wr = d & (op != ais_pkg::AIS_OP_LSUB);
            end
            ais_pkg::AIS_OP_NIBX: begin
                r = {1'b0, f[3:0], f[7:4]};
                wr = d;
            end
            ais_pkg::AIS_OP_XORL, ais_pkg::AIS_OP_XORF: begin
                r = {1'b0, ((op == ais_pkg::AIS_OP_XORL) ? k : f) ^ m_acc};
                m_f.zero = (r[7:0] == 8'h00);
                wr = d & (op == ais_pkg::AIS_OP_XORF);
            end
            ais_pkg::AIS_OP_DIRLD:
                if (k[2:0] >= 3'h5) m_dir[k[2:0] - 3'h5] = m_acc;
            ais_pkg::AIS_OP_SLEEP: begin
                m_f.sleep_entered = 1'b0;
                m_f.expiry = 1'b1;
            end
            default: ;
        endcase
        if (!wr) m_acc = r[7:0];
        req_i = '{1'b1, op, f[6:0], d, k};
        file_rd_i = f;
        @(negedge core_clk_i);
        check(acc_o, m_acc);
        check(8'(flags_o), 8'(m_f));
        check(8'(file_wr_o.we), 8'(wr));
        if (wr) check(file_wr_o.data, r[7:0]);
        if (wr) check(8'(file_wr_o.addr), 8'(f[6:0]));
        check(dir_a_o, m_dir[0]);
        check(dir_b_o, m_dir[1]);
        check(dir_c_o, m_dir[2]);
        check(8'(sleep_o), 8'(op == ais_pkg::AIS_OP_SLEEP));
    endtask : run
    task automatic setacc(input logic [7:0] v);
        run(ais_pkg::AIS_OP_XORL, 1'b0, v ^ m_acc, 8'h00);
    endtask : setacc
    // ticks on alternate cycles with no request pending
    task automatic ticks(input int n);
        req_i.valid = 1'b0;
        repeat (n) begin
            wdt_tick_i = 1'b1;
            @(negedge core_clk_i);
            wdt_tick_i = 1'b0;
            @(negedge core_clk_i);
        end
    endtask : ticks
    //==========================================================
    // tests
    initial begin
        m_f = ais_pkg::AIS_FLAGS_RST;
        m_dir = '{3{8'hff}};
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        @(negedge core_clk_i);
        check(8'(flags_o), 8'(m_f));
        check(dir_b_o, 8'hff);
        run(ais_pkg::AIS_OP_XORL, 1'b1, 8'h3c, 8'h00);
        run(ais_pkg::AIS_OP_XORL, 1'b0, 8'h3c, 8'h55);
        setacc(8'h05);
        run(ais_pkg::AIS_OP_LSUB, 1'b0, 8'h05, 8'h00);
        setacc(8'h06);
        run(ais_pkg::AIS_OP_LSUB, 1'b1, 8'h05, 8'h00);
        setacc(8'h18);
        run(ais_pkg::AIS_OP_FSUB, 1'b1, 8'h00, 8'h17);
        run(ais_pkg::AIS_OP_FSUB, 1'b0, 8'h00, 8'h18);
        setacc(8'h01);
        // first clears carry, second must then take the borrow
        run(ais_pkg::AIS_OP_FSUBB, 1'b1, 8'h00, 8'h00);
        run(ais_pkg::AIS_OP_FSUBB, 1'b1, 8'h00, 8'h02);
        $display("test subtract done");
        run(ais_pkg::AIS_OP_RRC, 1'b0, 8'h00, 8'h81);
        run(ais_pkg::AIS_OP_RRC, 1'b1, 8'h00, 8'h02);
        run(ais_pkg::AIS_OP_NIBX, 1'b1, 8'h00, 8'ha5);
        run(ais_pkg::AIS_OP_NIBX, 1'b0, 8'h00, 8'h0f);
        run(ais_pkg::AIS_OP_XORF, 1'b1, 8'h00, 8'hf0);
        run(ais_pkg::AIS_OP_XORF, 1'b0, 8'h00, 8'h3c);
        for (int i = 4; i < 8; i++) begin
            setacc(8'h40 + 8'(i));
            run(ais_pkg::AIS_OP_DIRLD, 1'b0, 8'(i), 8'h00);
        end
        run(ais_pkg::AIS_OP_NONE, 1'b1, 8'h00, 8'h77);
        $display("test datapath done");
        ticks(256);
        check(wdt_count_o, 8'h01);
        ticks(5);
        wdt_tick_i = 1'b1;
        run(ais_pkg::AIS_OP_SLEEP, 1'b0, 8'h00, 8'h00);
        wdt_tick_i = 1'b0;
        check(wdt_count_o, 8'h00);
        run(ais_pkg::AIS_OP_NONE, 1'b0, 8'h00, 8'h00);
        ticks(255);
        check(wdt_count_o, 8'h00);
        ticks(1);
        check(wdt_count_o, 8'h01);
        $display("test sleep done");
        end_of_test();
    end
    // the tests need about 1070 cycles; 5000 leaves ample margin
    initial begin
        repeat (5000) @(posedge core_clk_i);
        failures++;
        end_of_test();
    end
endmodule : test_alu_instruction_subset
`default_nettype wire
